// ===== hdl/bmc_pkg.sv
package bmc_pkg;
  localparam int NPORT = 2;
  localparam int CLK_NS = 10;
  localparam int UI_NS = 3333;
  localparam int HALF_CYC = UI_NS / (2 * CLK_NS);
  localparam int UI_CYC = UI_NS / CLK_NS;
  localparam int CW = 8;
  localparam int TW = 11;
  localparam logic [CW-1:0] HALF_LD = CW'(HALF_CYC - 1);
  localparam logic [TW-1:0] UI_INIT = TW'(UI_CYC);
  localparam logic [3:0] PRE_EDGES = 4'h8;

  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_DATA, TX_TAIL} bmc_txst_t;
  typedef enum logic {RX_HUNT, RX_DATA} bmc_rxst_t;

  typedef struct packed {
    bmc_txst_t st;
    logic [CW-1:0] cnt;
    logic lvl;
    logic oe;
    logic half;
    logic bitv;
    logic last;
    logic orient;
    logic rdy;
    logic a_oe;
    logic b_oe;
    logic unr;
  } bmc_tx_t;

  localparam bmc_tx_t TX_RST = '{st: TX_IDLE, cnt: '0, default: 1'b0};

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic s3;
    bmc_rxst_t st;
    logic [TW-1:0] t;
    logic [TW-1:0] ui;
    logic [3:0] edges;
    logic mid;
    logic valid;
    logic bitv;
    logic active;
  } bmc_rx_t;

  localparam bmc_rx_t RX_RST = '{s1: 2'h0, s2: 2'h0, st: RX_HUNT, t: '1, ui: UI_INIT,
                                 edges: 4'h0, default: 1'b0};
endpackage : bmc_pkg

// ===== hdl/bmc_cc_if.sv
interface bmc_cc_if;
  import bmc_pkg::*;

  logic [NPORT-1:0] dev_a_o;
  logic [NPORT-1:0] dev_a_oe;
  logic [NPORT-1:0] dev_b_o;
  logic [NPORT-1:0] dev_b_oe;
  wire [NPORT-1:0] far_o;
  wire [NPORT-1:0] far_oe;
  logic [NPORT-1:0] flip;
  logic [NPORT-1:0] lvl_a;
  logic [NPORT-1:0] lvl_b;
  logic [NPORT-1:0] far_lvl;

  // A released wire sits at its bias, which the receivers see as low.
  assign lvl_a = (dev_a_oe & dev_a_o) | (far_oe & far_o & ~flip);
  assign lvl_b = (dev_b_oe & dev_b_o) | (far_oe & far_o & flip);
  assign far_lvl = (flip & lvl_b) | (~flip & lvl_a);

  modport dev (output dev_a_o, dev_a_oe, dev_b_o, dev_b_oe, input lvl_a, lvl_b);
  modport far (output far_o, far_oe, input far_lvl);
endinterface : bmc_cc_if

// ===== hdl/bmc_rx.sv
module bmc_rx (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin pair, selection and enable.
  input wire logic [1:0] i_pin,
  input wire logic i_sel,
  input wire logic i_en,
  // Decoded bits.
  output logic o_valid,
  output logic o_bit,
  output logic o_active
);
  import bmc_pkg::*;

  bmc_rx_t q_ff;
  bmc_rx_t nxt_q;
  logic [TW-1:0] qtr;
  logic [TW-1:0] q34;
  logic [TW-1:0] lim;
  logic edg;

  always_comb begin
    nxt_q = q_ff;
    qtr = q_ff.ui >> 2;
    q34 = q_ff.ui - qtr;
    lim = q_ff.ui + (q_ff.ui >> 1);
    // Both pins are synchronised so that a change of selection never samples a raw pin.
    nxt_q.s1 = i_pin;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2[i_sel];
    edg = q_ff.s2[i_sel] ^ q_ff.s3;
    nxt_q.valid = 1'b0;
    if (q_ff.t != '1) begin
      nxt_q.t = q_ff.t + 1'b1;
    end
    if (!i_en) begin
      nxt_q.st = RX_HUNT;
      nxt_q.t = '1;
      nxt_q.edges = 4'h0;
      nxt_q.active = 1'b0;
      nxt_q.mid = 1'b0;
    end else if (edg) begin
      nxt_q.active = 1'b1;
      case (q_ff.st)
        RX_HUNT: begin
          nxt_q.t = '0;
          if ({1'b0, q_ff.t} > {q_ff.ui, 1'b0}) begin
            nxt_q.edges = 4'h1;
          end else begin
            nxt_q.ui = (q_ff.t >= q34) ? q_ff.t : {q_ff.t[TW-2:0], 1'b0};
            if (q_ff.edges != PRE_EDGES) begin
              nxt_q.edges = q_ff.edges + 1'b1;
            end else if (q_ff.t >= q34) begin
              nxt_q.st = RX_DATA;
              nxt_q.mid = 1'b0;
            end
          end
        end
        RX_DATA: begin
          if (q_ff.t >= q34) begin
            nxt_q.valid = 1'b1;
            nxt_q.bitv = q_ff.mid;
            nxt_q.mid = 1'b0;
            nxt_q.t = '0;
          end else if (q_ff.t >= qtr) begin
            nxt_q.mid = 1'b1;
          end
        end
        default: begin
          nxt_q.st = RX_HUNT;
        end
      endcase
    end else if (q_ff.t > lim) begin
      nxt_q.st = RX_HUNT;
      nxt_q.active = 1'b0;
      nxt_q.edges = 4'h0;
      nxt_q.mid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q_ff <= RX_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_valid = q_ff.valid;
  assign o_bit = q_ff.bitv;
  assign o_active = q_ff.active;
endmodule : bmc_rx

// ===== hdl/bmc_far.sv
module bmc_far #(
  parameter int PORT = 0
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Transmit bit stream.
  input wire logic i_tx_valid,
  input wire logic i_tx_bit,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  output logic o_tx_busy,
  // Receive bit stream.
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic o_rx_active,
  // Shared wire.
  bmc_cc_if.far cc
);
  import bmc_pkg::*;

  bmc_tx_t q_ff;
  bmc_tx_t nxt_q;
  logic take;

  assign take = q_ff.rdy & i_tx_valid;

  always_comb begin
    nxt_q = q_ff;
    if (q_ff.cnt != '0) begin
      nxt_q.cnt = q_ff.cnt - 1'b1;
    end
    case (q_ff.st)
      TX_IDLE: begin
        if (take) begin
          nxt_q.st = TX_LEAD;
          nxt_q.oe = 1'b1;
          nxt_q.lvl = 1'b0;
          nxt_q.cnt = HALF_LD;
          nxt_q.bitv = i_tx_bit;
          nxt_q.last = i_tx_last;
        end
      end
      TX_LEAD: begin
        if (q_ff.cnt == '0) begin
          nxt_q.st = TX_DATA;
          nxt_q.lvl = ~q_ff.lvl;
          nxt_q.half = 1'b0;
          nxt_q.cnt = HALF_LD;
        end
      end
      TX_DATA: begin
        if (q_ff.cnt == '0) begin
          nxt_q.cnt = HALF_LD;
          nxt_q.half = ~q_ff.half;
          if (!q_ff.half) begin
            nxt_q.lvl = q_ff.lvl ^ q_ff.bitv;
          end else begin
            nxt_q.lvl = ~q_ff.lvl;
            nxt_q.bitv = i_tx_bit;
            nxt_q.last = i_tx_last;
            if (!take) begin
              nxt_q.st = TX_TAIL;
            end
          end
        end
      end
      TX_TAIL: begin
        if (q_ff.cnt == '0) begin
          nxt_q.st = TX_IDLE;
          nxt_q.oe = 1'b0;
        end
      end
      default: begin
        nxt_q.st = TX_IDLE;
      end
    endcase
    nxt_q.rdy = (nxt_q.st == TX_IDLE && !o_rx_active) ||
                (nxt_q.st == TX_DATA && nxt_q.half && nxt_q.cnt == '0 && !nxt_q.last);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q_ff <= TX_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  bmc_rx u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin({1'b0, cc.far_lvl[PORT]}),
    .i_sel(1'b0),
    .i_en(~q_ff.oe),
    .o_valid(o_rx_valid),
    .o_bit(o_rx_bit),
    .o_active(o_rx_active)
  );

  assign cc.far_o[PORT] = q_ff.lvl;
  assign cc.far_oe[PORT] = q_ff.oe;
  assign o_tx_ready = q_ff.rdy;
  assign o_tx_busy = q_ff.oe;
endmodule : bmc_far

// ===== hdl/bmc_dev.sv
// Function
// - Every bit opens with a line transition.
// - Ones add a mid-bit transition; zeros hold.
// - Running disparity stays within half a bit.
// - Preamble starts by driving the line low.
// - Receiver locks despite a missing first edge.
// - Closing edge follows the final EOP bit.
// - Drive while sending, release line when idle.
// - Use only the orientation-selected CC pin.
// - One talker at a time; others listen.
// - Independent transmitter and receiver per port.
// - Coexist with the DC bias on active pin.
// - Mid-bit edge means one, none means zero.
module bmc_dev (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Cable orientation per port, high selects pin b.
  input wire logic [bmc_pkg::NPORT-1:0] i_orient,
  // Transmit bit streams.
  input wire logic [bmc_pkg::NPORT-1:0] i_tx_valid,
  input wire logic [bmc_pkg::NPORT-1:0] i_tx_bit,
  input wire logic [bmc_pkg::NPORT-1:0] i_tx_last,
  output logic [bmc_pkg::NPORT-1:0] o_tx_ready,
  output logic [bmc_pkg::NPORT-1:0] o_tx_busy,
  output logic [bmc_pkg::NPORT-1:0] o_tx_underrun,
  // Receive bit streams.
  output logic [bmc_pkg::NPORT-1:0] o_rx_valid,
  output logic [bmc_pkg::NPORT-1:0] o_rx_bit,
  output logic [bmc_pkg::NPORT-1:0] o_rx_active,
  // Configuration channel pins of both ports.
  bmc_cc_if.dev cc
);
  import bmc_pkg::*;

  // Each port is a complete copy with its own state, so the two never share timing.
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    bmc_tx_t st_ff;
    bmc_tx_t nxt_st;
    logic take;

    assign take = st_ff.rdy & i_tx_valid[g];

    always_comb begin
      nxt_st = st_ff;
      nxt_st.unr = 1'b0;
      if (st_ff.cnt != '0) begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      case (st_ff.st)
        TX_IDLE: begin
          if (take) begin
            nxt_st.st = TX_LEAD;
            nxt_st.oe = 1'b1;
            nxt_st.lvl = 1'b0;
            nxt_st.cnt = HALF_LD;
            nxt_st.bitv = i_tx_bit[g];
            nxt_st.last = i_tx_last[g];
            // The pin is frozen per packet so a late orientation change cannot split it.
            nxt_st.orient = i_orient[g];
          end
        end
        TX_LEAD: begin
          if (st_ff.cnt == '0) begin
            nxt_st.st = TX_DATA;
            nxt_st.lvl = ~st_ff.lvl;
            nxt_st.half = 1'b0;
            nxt_st.cnt = HALF_LD;
          end
        end
        TX_DATA: begin
          if (st_ff.cnt == '0) begin
            nxt_st.cnt = HALF_LD;
            nxt_st.half = ~st_ff.half;
            if (!st_ff.half) begin
              nxt_st.lvl = st_ff.lvl ^ st_ff.bitv;
            end else if (take) begin
              nxt_st.lvl = ~st_ff.lvl;
              nxt_st.bitv = i_tx_bit[g];
              nxt_st.last = i_tx_last[g];
            end else begin
              // A missing bit ends the packet cleanly rather than stretching a symbol.
              nxt_st.st = TX_TAIL;
              nxt_st.lvl = ~st_ff.lvl;
              nxt_st.unr = ~st_ff.last;
            end
          end
        end
        TX_TAIL: begin
          if (st_ff.cnt == '0) begin
            nxt_st.st = TX_IDLE;
            nxt_st.oe = 1'b0;
          end
        end
        default: begin
          nxt_st.st = TX_IDLE;
          nxt_st.oe = 1'b0;
        end
      endcase
      // Ready comes from the next state so that it stands in the boundary cycle itself.
      nxt_st.rdy = (nxt_st.st == TX_IDLE && !o_rx_active[g]) ||
                   (nxt_st.st == TX_DATA && nxt_st.half &&
                    nxt_st.cnt == '0 && !nxt_st.last);
      nxt_st.a_oe = nxt_st.oe & ~nxt_st.orient;
      nxt_st.b_oe = nxt_st.oe & nxt_st.orient;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        st_ff <= TX_RST;
      end else begin
        st_ff <= nxt_st;
      end
    end

    // The receiver is deaf while this port talks, so its own echo is never decoded.
    bmc_rx u_rx (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin({cc.lvl_b[g], cc.lvl_a[g]}),
      .i_sel(i_orient[g]),
      .i_en(~st_ff.oe),
      .o_valid(o_rx_valid[g]),
      .o_bit(o_rx_bit[g]),
      .o_active(o_rx_active[g])
    );

    assign cc.dev_a_o[g] = st_ff.lvl;
    assign cc.dev_b_o[g] = st_ff.lvl;
    assign cc.dev_a_oe[g] = st_ff.a_oe;
    assign cc.dev_b_oe[g] = st_ff.b_oe;
    assign o_tx_ready[g] = st_ff.rdy;
    assign o_tx_busy[g] = st_ff.oe;
    assign o_tx_underrun[g] = st_ff.unr;
  end
endmodule : bmc_dev

// ===== tb/bmc_cc_sva.sv
module bmc_cc_sva (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Wire signals.
  input wire logic [1:0] dev_a_o,
  input wire logic [1:0] dev_a_oe,
  input wire logic [1:0] dev_b_o,
  input wire logic [1:0] dev_b_oe,
  input wire logic [1:0] far_o,
  input wire logic [1:0] far_oe,
  input wire logic [1:0] flip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oe, lv, chg;
  logic oe_ff, lv_ff;
  logic [9:0] cnt_ff;
  assign oe = dev_a_oe[0] | dev_b_oe[0];
  assign lv = flip[0] ? dev_b_o[0] : dev_a_o[0];
  assign chg = lv != lv_ff;
  // The run counter saturates so a long idle spell cannot wrap into a legal run length.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oe_ff <= 1'b0;
      lv_ff <= 1'b0;
      cnt_ff <= 10'h0;
    end else begin
      oe_ff <= oe;
      lv_ff <= lv;
      cnt_ff <= (chg || (oe && !oe_ff)) ? 10'h1 : cnt_ff + {9'h0, cnt_ff != 10'h3FF};
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_lead0; $rose(oe) |-> (!lv) [*8]; endproperty
  a_lead0: assert property (p_lead0) else $error("lead not low");
  property p_first0; $rose(oe) |-> ##165 !lv ##1 lv; endproperty
  a_first0: assert property (p_first0) else $error("first edge late");
  property p_run0; chg && oe && oe_ff |-> cnt_ff == 10'hA6 || cnt_ff == 10'h14C; endproperty
  a_run0: assert property (p_run0) else $error("bad run length");
  property p_rel0; $fell(oe) |-> cnt_ff == 10'hA6; endproperty
  a_rel0: assert property (p_rel0) else $error("bad release");
  property p_farlead; $rose(far_oe[0]) |-> !far_o[0]; endproperty
  a_farlead: assert property (p_farlead) else $error("far lead not low");
  property p_talk; ((dev_a_oe | dev_b_oe) & far_oe) == 2'h0; endproperty
  a_talk: assert property (p_talk) else $error("two talkers");
  property p_pin; (dev_a_oe & flip) == 2'h0 && (dev_b_oe & ~flip) == 2'h0; endproperty
  a_pin: assert property (p_pin) else $error("wrong pin");
  property p_lead1; $rose(dev_a_oe[1] | dev_b_oe[1]) |-> !(dev_a_o[1] | dev_b_o[1]); endproperty
  a_lead1: assert property (p_lead1) else $error("port 1 lead");
endmodule : bmc_cc_sva

// ===== tb/tb_top.sv
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst;
  logic [1:0] orient, unr_seen;
  logic [3:0] tv, tb, tl, ra_q;
  wire [3:0] rdy, rv, rb, ra;
  wire [1:0] d_unr;
  wire [3:0] busy;
  logic [11:0] exp_v;
  int unr_n;
  int fail_count, checked;
  logic [11:0] exp_q[4][$];
  logic [35:0] hist[4];
  bmc_cc_if cc();
  bmc_dev i_bmc_dev (.i_clk(i_clk), .i_rst(i_rst), .i_orient(orient),
    .i_tx_valid(tv[3:2]), .i_tx_bit(tb[3:2]), .i_tx_last(tl[3:2]), .o_tx_ready(rdy[3:2]),
    .o_tx_busy(busy[3:2]), .o_tx_underrun(d_unr), .o_rx_valid(rv[1:0]), .o_rx_bit(rb[1:0]),
    .o_rx_active(ra[1:0]), .cc(cc));
  for (genvar p = 0; p < 2; p++) begin : g_far
    bmc_far #(.PORT(p)) i_bmc_far (.i_clk(i_clk), .i_rst(i_rst), .i_tx_valid(tv[p]),
      .i_tx_bit(tb[p]), .i_tx_last(tl[p]), .o_tx_ready(rdy[p]), .o_tx_busy(busy[p]),
      .o_rx_valid(rv[p+2]), .o_rx_bit(rb[p+2]), .o_rx_active(ra[p+2]), .cc(cc));
  end
  bmc_cc_sva i_sva (.i_clk(i_clk), .i_rst(i_rst), .dev_a_o(cc.dev_a_o),
    .dev_a_oe(cc.dev_a_oe), .dev_b_o(cc.dev_b_o), .dev_b_oe(cc.dev_b_oe),
    .far_o(cc.far_o), .far_oe(cc.far_oe), .flip(cc.flip));
  task automatic wrap_up(input bit tmo);
    if (tmo) fail_count++;
    `CHK(unr_seen, 2'h1)
    `CHK(unr_n, 1)
    `CHK(busy, 4'h0)
    for (int k = 0; k < 4; k++) `CHK(exp_q[k].size(), 0)
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Sender k feeds receiver k; preamble bits are not compared since lock eats some.
  task automatic send(input int k, input logic [11:0] pl, input bit cut);
    logic [35:0] w;
    int n;
    w = {24'hAAAAAA, pl};
    exp_q[k].push_back(pl);
    for (int i = 35; i >= 0; i--) begin
      tv[k] <= 1'b1;
      tb[k] <= w[i];
      // A cut packet never marks its last bit, so the transmitter runs dry after it.
      tl[k] <= i == 0 && !cut;
      n = 0;
      do begin
        @(negedge i_clk);
        n++;
      end while (rdy[k] !== 1'b1 && n < 3000);
      if (rdy[k] !== 1'b1) wrap_up(1'b1);
      `CHK(busy[k], i < 35)
      @(posedge i_clk);
    end
    tv[k] <= 1'b0;
  endtask : send
  always @(negedge i_clk) begin
    unr_seen = unr_seen | d_unr;
    for (int u = 0; u < 2; u++) begin
      if (d_unr[u] === 1'b1) unr_n++;
    end
    for (int k = 0; k < 4; k++) begin
      if (rv[k] === 1'b1) hist[k] = {hist[k][34:0], rb[k]};
      if (ra_q[k] === 1'b1 && ra[k] === 1'b0 && exp_q[k].size() > 0) begin
        exp_v = exp_q[k].pop_front();
        `CHK(hist[k][11:0], exp_v)
      end
      ra_q[k] = ra[k];
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_rst = 1'b1;
    orient = 2'h0;
    cc.flip = 2'h0;
    tv = 4'h0;
    tb = 4'h0;
    tl = 4'h0;
    unr_seen = 2'h0;
    unr_n = 0;
    fail_count = 0;
    checked = 0;
    void'($urandom(32'hB6F1630D));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    // Ports run opposite directions at once, and each side sees both orientations.
    for (int r = 0; r < 4; r++) begin
      repeat (1200) @(posedge i_clk);
      orient <= {r[0] ^ r[1], r[0]};
      cc.flip <= {r[0] ^ r[1], r[0]};
      repeat (600) @(posedge i_clk);
      fork
        send(r[1] ? 0 : 2, 12'($urandom), 1'b0);
        send(r[1] ? 3 : 1, 12'($urandom), 1'b0);
      join
    end
    // One packet on port 0 ends without its last mark and must report one underrun.
    repeat (1200) @(posedge i_clk);
    send(2, 12'($urandom), 1'b1);
    repeat (1200) @(posedge i_clk);
    wrap_up(1'b0);
  end
endmodule : tb_top
